//--- core/xbuf_pkg.sv
// Purpose: shared constants and types for the exchange buffer unit
// Assumes: dits receivers, transmitters and the 1553a terminal run on clk
// Notes:   words are 32 bits with the label in the low byte
package xbuf_pkg;
  localparam int N_RX            = 3;
  localparam int N_TX            = 2;
  localparam int WORD_W          = 32;
  localparam int HALF_W          = 16;
  localparam int LABEL_W         = 8;
  localparam int SA_W            = 5;
  localparam int DN_W            = HALF_W + SA_W;
  localparam int FIFO_DEPTH      = 8;
  localparam int CNT_W           = 16;
  localparam int RX_IDX_W        = $clog2(N_RX);
  localparam int TX_IDX_W        = (N_TX > 1) ? $clog2(N_TX) : 1;
  localparam int CLK_MHZ         = 20;
  localparam int WORD_PERIOD_US  = 320;
  localparam int WORD_PERIOD_CYC = WORD_PERIOD_US * CLK_MHZ;
  localparam logic [SA_W-1:0]   TX_SA_BASE = 5'h01;
  localparam logic [WORD_W-1:0] WORD_RST   = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  CNT_RST    = 16'h0000;

  typedef logic [WORD_W-1:0]  word_t;
  typedef logic [HALF_W-1:0]  half_t;
  typedef logic [LABEL_W-1:0] label_t;
  typedef logic [SA_W-1:0]    sa_t;
  typedef logic [CNT_W-1:0]   cnt_t;

  typedef enum logic [2:0] {
    UP_IDLE = 3'b001,
    UP_LO   = 3'b010,
    UP_HI   = 3'b100
  } up_state_t;

  typedef enum logic [2:0] {
    DN_LO   = 3'b001,
    DN_HI   = 3'b010,
    DN_SEND = 3'b100
  } dn_state_t;

  function automatic label_t label_of(word_t w);
    return w[LABEL_W-1:0];
  endfunction
endpackage

//--- core/fifo_if.sv
// Purpose: valid/ready stream between the unit and its queues
// Assumes: a beat moves when valid and ready are both high at a clk edge
// Notes:   no clocking block
interface fifo_if #(parameter int W = 16);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

//--- core/word_fifo.sv
// Purpose: first-in first-out queue with registered read data
// Assumes: single clock
// Notes:   in_s.ready and out_s data/valid come from flops
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  fifo_if.snk      in_s,
  // drain side
  fifo_if.src      out_s
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
    logic                        in_ready;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic   push;
  logic   load;

  always_comb
  begin
    nxt_st = st_ff;
    push   = in_s.valid && st_ff.in_ready;
    load   = (st_ff.count != '0) && (!st_ff.out_valid || out_s.ready);
    if (push)
    begin
      nxt_st.mem[st_ff.wptr] = in_s.data;
      nxt_st.wptr            = st_ff.wptr + 1'b1;
    end
    if (out_s.ready)
      nxt_st.out_valid = 1'b0;
    if (load)
    begin
      nxt_st.out_data  = st_ff.mem[st_ff.rptr];
      nxt_st.out_valid = 1'b1;
      nxt_st.rptr      = st_ff.rptr + 1'b1;
    end
    if (push && !load)
      nxt_st.count = st_ff.count + 1'b1;
    else if (load && !push)
      nxt_st.count = st_ff.count - 1'b1;
    nxt_st.in_ready = (nxt_st.count < (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff          <= '0;
      st_ff.in_ready <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign in_s.ready  = st_ff.in_ready;
  assign out_s.valid = st_ff.out_valid;
  assign out_s.data  = st_ff.out_data;
endmodule // word_fifo

//--- core/rx_slot.sv
// Purpose: one dits receiver holding slot with label filter
// Assumes: in_valid is a one-cycle pulse per complete valid word
// Notes:   a new word in the cycle of take is kept
module rx_slot #(
  parameter int GAP_CYC = 6400
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_b,
  // receiver side
  input  wire xbuf_pkg::word_t  in_word,
  input  wire logic             in_valid,
  input  wire xbuf_pkg::label_t own_label,
  // arbiter side
  input  wire logic             take,
  output logic                  pending,
  output xbuf_pkg::word_t       word,
  // status
  output logic                  drop,
  output logic                  fast
);
  import xbuf_pkg::*;
  localparam int GW = $clog2(GAP_CYC + 1);

  typedef struct packed {
    logic          pending;
    word_t         word;
    logic          drop;
    logic          fast;
    logic [GW-1:0] gap;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.drop = 1'b0;
    nxt_st.fast = 1'b0;
    if (st_ff.gap != '0)
      nxt_st.gap = st_ff.gap - 1'b1;
    if (take)
      nxt_st.pending = 1'b0;
    if (in_valid && label_of(in_word) == own_label)
    begin
      nxt_st.fast = (st_ff.gap != '0);
      nxt_st.gap  = GW'(GAP_CYC - 1);
      if (st_ff.pending && !take)
        nxt_st.drop = 1'b1;
      else
      begin
        nxt_st.pending = 1'b1;
        nxt_st.word    = in_word;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign pending = st_ff.pending;
  assign word    = st_ff.word;
  assign drop    = st_ff.drop;
  assign fast    = st_ff.fast;
endmodule // rx_slot

//--- core/exchange_buffer_unit.sv
// Purpose: exchange buffer between dits receivers/transmitters and a 1553a terminal
// Assumes: receivers, transmitters and terminal are logic on clk
// Notes:   words cross the terminal side as two 16-bit halves, low half first
// How it works
// - received words stored, forwarded with label
// - terminal words resent whole, label included
// - receiver keeps only its own label
// - one transmitter per shared-label group
// - subaddress selects the output transmitter
// - storage allows simultaneous reception, small delay
// - receivers fill queue drained by terminal
// - terminal fills separate queue feeding transmitters
// - receiver flags each complete valid word
// - word moved only when internal bus free
// - one word per 320 us sustained
// - terminal reaches queues directly, no copying
module exchange_buffer_unit #(
  parameter int WORD_GAP_CYC = xbuf_pkg::WORD_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  rst_b,
  // dits receivers
  input  wire xbuf_pkg::word_t  [xbuf_pkg::N_RX-1:0] rx_word,
  input  wire logic             [xbuf_pkg::N_RX-1:0] rx_valid,
  input  wire xbuf_pkg::label_t [xbuf_pkg::N_RX-1:0] rx_own_label,
  output logic                  [xbuf_pkg::N_RX-1:0] rx_drop,
  output logic                  [xbuf_pkg::N_RX-1:0] rx_fast,
  // terminal, toward bus controller
  output xbuf_pkg::half_t                            t_data,
  output logic                                       t_valid,
  input  wire logic                                  t_ready,
  // terminal, from bus controller
  input  wire xbuf_pkg::half_t                       r_data,
  input  wire xbuf_pkg::sa_t                         r_subaddr,
  input  wire logic                                  r_valid,
  output logic                                       r_ready,
  // dits transmitters
  output xbuf_pkg::word_t       [xbuf_pkg::N_TX-1:0] tx_word,
  output logic                  [xbuf_pkg::N_TX-1:0] tx_valid,
  input  wire logic             [xbuf_pkg::N_TX-1:0] tx_ready,
  // status
  output logic                                       sa_reject,
  output xbuf_pkg::cnt_t                             up_count,
  output xbuf_pkg::cnt_t                             dn_count
);
  import xbuf_pkg::*;

  typedef struct packed {
    up_state_t                  up_state;
    logic [RX_IDX_W-1:0]        rr;
    word_t                      up_stage;
    logic [N_RX-1:0]            take;
    dn_state_t                  dn_state;
    word_t                      dn_word;
    sa_t                        dn_sa;
    word_t [N_TX-1:0]           tx_word;
    logic [N_TX-1:0]            tx_valid;
    logic                       sa_reject;
    cnt_t                       up_count;
    cnt_t                       dn_count;
  } state_t;

  state_t             st_ff;
  state_t             nxt_st;
  logic  [N_RX-1:0]   slot_pend;
  word_t [N_RX-1:0]   slot_word;

  fifo_if #(.W(HALF_W)) up_in ();
  fifo_if #(.W(HALF_W)) up_out ();
  fifo_if #(.W(DN_W))   dn_in ();
  fifo_if #(.W(DN_W))   dn_out ();

  // subaddress to transmitter decode
  function automatic logic sa_ok(sa_t sa);
    sa_t d;
    d = sa - TX_SA_BASE;
    return (sa >= TX_SA_BASE) && (int'(d) < N_TX);
  endfunction

  function automatic logic [TX_IDX_W-1:0] sa_idx(sa_t sa);
    sa_t d;
    d = sa - TX_SA_BASE;
    return d[TX_IDX_W-1:0];
  endfunction

  // receiver slots
  for (genvar g = 0; g < N_RX; g++)
  begin : g_rx
    rx_slot #(.GAP_CYC(WORD_GAP_CYC)) u_slot (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_word   (rx_word[g]),
      .in_valid  (rx_valid[g]),
      .own_label (rx_own_label[g]),
      .take      (st_ff.take[g]),
      .pending   (slot_pend[g]),
      .word      (slot_word[g]),
      .drop      (rx_drop[g]),
      .fast      (rx_fast[g])
    );
  end

  // queue toward the terminal
  word_fifo #(.WIDTH(HALF_W), .DEPTH(FIFO_DEPTH)) u_up_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .in_s  (up_in),
    .out_s (up_out)
  );

  // queue from the terminal
  word_fifo #(.WIDTH(DN_W), .DEPTH(FIFO_DEPTH)) u_dn_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .in_s  (dn_in),
    .out_s (dn_out)
  );

  // uplink push, low half then high half
  assign up_in.valid = (st_ff.up_state != UP_IDLE);
  assign up_in.data  = (st_ff.up_state == UP_HI) ? st_ff.up_stage[WORD_W-1:HALF_W]
                                                 : st_ff.up_stage[HALF_W-1:0];

  // terminal drains and fills the queues directly
  assign t_data       = up_out.data;
  assign t_valid      = up_out.valid;
  assign up_out.ready = t_ready;
  assign dn_in.data   = {r_subaddr, r_data};
  assign dn_in.valid  = r_valid;
  assign r_ready      = dn_in.ready;
  assign dn_out.ready = (st_ff.dn_state == DN_LO) || (st_ff.dn_state == DN_HI);

  always_comb
  begin
    int                  c;
    logic                found;
    logic [TX_IDX_W-1:0] ti;
    c         = 0;
    found     = 1'b0;
    ti        = sa_idx(st_ff.dn_sa);
    nxt_st           = st_ff;
    nxt_st.take      = '0;
    nxt_st.sa_reject = 1'b0;

    // uplink: round-robin grant when the internal path is free
    unique case (st_ff.up_state)
      UP_IDLE:
      begin
        for (int k = 0; k < N_RX; k++)
        begin
          c = (int'(st_ff.rr) + 1 + k) % N_RX;
          if (!found && slot_pend[c])
          begin
            found             = 1'b1;
            nxt_st.rr         = RX_IDX_W'(c);
            nxt_st.up_stage   = slot_word[c];
            nxt_st.take[c]    = 1'b1;
            nxt_st.up_state   = UP_LO;
          end
        end
      end
      UP_LO:
      begin
        if (up_in.ready)
          nxt_st.up_state = UP_HI;
      end
      UP_HI:
      begin
        if (up_in.ready)
        begin
          nxt_st.up_state = UP_IDLE;
          nxt_st.up_count = st_ff.up_count + 1'b1;
        end
      end
    endcase

    // transmitter holding registers empty on acceptance
    for (int i = 0; i < N_TX; i++)
    begin
      if (st_ff.tx_valid[i] && tx_ready[i])
        nxt_st.tx_valid[i] = 1'b0;
    end

    // downlink: rejoin halves and route by subaddress
    unique case (st_ff.dn_state)
      DN_LO:
      begin
        if (dn_out.valid)
        begin
          nxt_st.dn_word[HALF_W-1:0] = dn_out.data[HALF_W-1:0];
          nxt_st.dn_sa               = dn_out.data[DN_W-1:HALF_W];
          nxt_st.dn_state            = DN_HI;
        end
      end
      DN_HI:
      begin
        if (dn_out.valid)
        begin
          nxt_st.dn_word[WORD_W-1:HALF_W] = dn_out.data[HALF_W-1:0];
          if (sa_ok(st_ff.dn_sa))
            nxt_st.dn_state = DN_SEND;
          else
          begin
            nxt_st.sa_reject = 1'b1;
            nxt_st.dn_state  = DN_LO;
          end
        end
      end
      DN_SEND:
      begin
        if (!st_ff.tx_valid[ti])
        begin
          nxt_st.tx_word[ti]  = st_ff.dn_word;
          nxt_st.tx_valid[ti] = 1'b1;
          nxt_st.dn_count     = st_ff.dn_count + 1'b1;
          nxt_st.dn_state     = DN_LO;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff          <= '0;
      st_ff.up_state <= UP_IDLE;
      st_ff.up_stage <= WORD_RST;
      st_ff.dn_state <= DN_LO;
      st_ff.dn_word  <= WORD_RST;
      st_ff.up_count <= CNT_RST;
      st_ff.dn_count <= CNT_RST;
    end
    else
      st_ff <= nxt_st;
  end

  assign tx_word   = st_ff.tx_word;
  assign tx_valid  = st_ff.tx_valid;
  assign sa_reject = st_ff.sa_reject;
  assign up_count  = st_ff.up_count;
  assign dn_count  = st_ff.dn_count;
endmodule // exchange_buffer_unit

//--- verif/exchange_buffer_unit_checker.sv
// Purpose: port assertions for the exchange buffer unit
// Assumes: one clock, async active-low reset
// Notes:   attached by the bind at the foot
module exchange_buffer_unit_checker #(
  parameter int WORD_GAP_CYC = 16
) (
  // clock and reset
  input wire logic                                  clk,
  input wire logic                                  rst_b,
  // receivers
  input wire xbuf_pkg::word_t  [xbuf_pkg::N_RX-1:0] rx_word,
  input wire logic             [xbuf_pkg::N_RX-1:0] rx_valid,
  input wire xbuf_pkg::label_t [xbuf_pkg::N_RX-1:0] rx_own_label,
  input wire logic             [xbuf_pkg::N_RX-1:0] rx_drop,
  input wire logic             [xbuf_pkg::N_RX-1:0] rx_fast,
  // terminal uplink
  input wire xbuf_pkg::half_t                       t_data,
  input wire logic                                  t_valid,
  input wire logic                                  t_ready,
  // transmitters
  input wire xbuf_pkg::word_t  [xbuf_pkg::N_TX-1:0] tx_word,
  input wire logic             [xbuf_pkg::N_TX-1:0] tx_valid,
  input wire logic             [xbuf_pkg::N_TX-1:0] tx_ready,
  input wire logic                                  sa_reject
);
  timeunit 1ns;
  timeprecision 1ns;
  import xbuf_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence hit0;
    rx_valid[0] && rx_word[0][LABEL_W-1:0] == rx_own_label[0];
  endsequence
  sequence miss0;
    rx_valid[0] && rx_word[0][LABEL_W-1:0] != rx_own_label[0];
  endsequence
  sequence up_stall;
    t_valid && !t_ready;
  endsequence
  up_hold_a: assert property (up_stall |=> t_valid && $stable(t_data))
    else $error("uplink half changed while stalled");
  up_latency_a: assert property (hit0 ##0 !t_valid |-> ##[4:40] t_valid)
    else $error("accepted word not offered");
  foreign_word_a: assert property (miss0 |=> !rx_drop[0] && !rx_fast[0])
    else $error("foreign label word acted on");
  drop_cause_a: assert property (rx_drop[2] |-> $past(rx_valid[2])
    && $past(rx_word[2][7:0]) == $past(rx_own_label[2]))
    else $error("drop without own word");
  tx0_hold_a: assert property (tx_valid[0] && !tx_ready[0] |=> tx_valid[0] && $stable(tx_word[0]))
    else $error("transmitter 0 word not held");
  tx1_hold_a: assert property (tx_valid[1] && !tx_ready[1] |=> tx_valid[1] && $stable(tx_word[1]))
    else $error("transmitter 1 word not held");
  tx_release_a: assert property (tx_valid[0] && tx_ready[0] |=> !tx_valid[0])
    else $error("taken word still offered");
  reject_pulse_a: assert property (sa_reject |=> !sa_reject)
    else $error("reject pulse too long");
endmodule // exchange_buffer_unit_checker

bind exchange_buffer_unit exchange_buffer_unit_checker #(
  .WORD_GAP_CYC(WORD_GAP_CYC)
) exchange_buffer_unit_checker_i (
  .clk(clk), .rst_b(rst_b), .rx_word(rx_word), .rx_valid(rx_valid),
  .rx_own_label(rx_own_label), .rx_drop(rx_drop), .rx_fast(rx_fast),
  .t_data(t_data), .t_valid(t_valid), .t_ready(t_ready), .tx_word(tx_word),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .sa_reject(sa_reject)
);

//--- verif/bus_ctrl_model.sv
// Purpose: behavioural bus controller beyond the terminal
// Assumes: halves arrive low first
// Notes:   second half carries a scrambled subaddress
module bus_ctrl_model (
  // clock
  input  wire logic            clk,
  // halves from the unit
  input  wire xbuf_pkg::half_t t_data,
  input  wire logic            t_valid,
  output logic                 t_ready,
  // halves to the unit
  output xbuf_pkg::half_t      r_data,
  output xbuf_pkg::sa_t        r_subaddr,
  output logic                 r_valid,
  input  wire logic            r_ready,
  // bench controls
  input  wire logic            stall,
  input  wire logic            echo,
  input  wire xbuf_pkg::sa_t   route_sa
);
  timeunit 1ns;
  timeprecision 1ns;
  import xbuf_pkg::*;
  half_t lo_q;
  logic  hi_q = 1'b0;
  word_t q[$];
  word_t w;
  always @(posedge clk)
  begin
    t_ready <= !stall;
    if (t_valid && t_ready)
    begin
      if (hi_q && echo) q.push_back({t_data, lo_q});
      lo_q <= t_data;
      hi_q <= !hi_q;
    end
  end
  initial
  begin
    r_valid = 1'b0;
    r_data = 16'h0000;
    r_subaddr = 5'h00;
    forever
    begin
      @(posedge clk);
      if (q.size() != 0)
      begin
        w = q.pop_front();
        r_data <= w[15:0];
        r_subaddr <= route_sa;
        r_valid <= 1'b1;
        do @(posedge clk); while (r_ready !== 1'b1);
        r_data <= w[31:16];
        r_subaddr <= ~route_sa;
        do @(posedge clk); while (r_ready !== 1'b1);
        r_valid <= 1'b0;
        r_data <= ~w[31:16];
      end
    end
  end
endmodule // bus_ctrl_model

//--- verif/test_exchange_buffer_unit.sv
// Purpose: self-checking bench for the exchange buffer unit
// Assumes: bus_ctrl_model answers on the terminal side
// Notes:   word gap shortened to 16 cycles
module test_exchange_buffer_unit;
  timeunit 1ns;
  timeprecision 1ns;
  import xbuf_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic stall = 1'b0;
  logic echo = 1'b0;
  logic rej_seen = 1'b0;
  logic hi_m = 1'b0;
  logic clr_req = 1'b0;
  logic t_valid, t_ready, r_valid, r_ready, sa_reject;
  logic [N_RX-1:0] rx_valid = '0, drop_seen = '0, fast_seen = '0, rx_drop, rx_fast;
  logic [N_TX-1:0] tx_valid, tx_ready = '0;
  word_t [N_RX-1:0] rx_word = '0;
  word_t [N_TX-1:0] tx_word;
  half_t t_data, r_data, lo_m;
  sa_t r_subaddr, route_sa = 5'h01;
  cnt_t up_count, dn_count;
  word_t up_q[$];
  int fails = 0, compares = 0;

  exchange_buffer_unit #(.WORD_GAP_CYC(16)) exchange_buffer_unit_i (
    .clk(clk), .rst_b(rst_b), .rx_word(rx_word), .rx_valid(rx_valid),
    .rx_own_label({8'h33, 8'h22, 8'h11}), .rx_drop(rx_drop), .rx_fast(rx_fast),
    .t_data(t_data), .t_valid(t_valid), .t_ready(t_ready), .r_data(r_data),
    .r_subaddr(r_subaddr), .r_valid(r_valid), .r_ready(r_ready), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .sa_reject(sa_reject),
    .up_count(up_count), .dn_count(dn_count));
  bus_ctrl_model bus_ctrl_model_i (
    .clk(clk), .t_data(t_data), .t_valid(t_valid), .t_ready(t_ready), .r_data(r_data),
    .r_subaddr(r_subaddr), .r_valid(r_valid), .r_ready(r_ready), .stall(stall),
    .echo(echo), .route_sa(route_sa));

  always #25 clk = ~clk;

  // collect uplink words and sticky status pulses
  always @(posedge clk)
  begin
    if (clr_req)
    begin
      drop_seen <= '0;
      fast_seen <= '0;
      rej_seen <= 1'b0;
      up_q.delete();
    end
    else
    begin
      drop_seen <= drop_seen | rx_drop;
      fast_seen <= fast_seen | rx_fast;
      rej_seen <= rej_seen | sa_reject;
    end
    if (t_valid && t_ready)
    begin
      if (hi_m && !clr_req) up_q.push_back({t_data, lo_m});
      lo_m <= t_data;
      hi_m <= !hi_m;
    end
  end

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic clr();
    @(posedge clk);
    clr_req <= 1'b1;
    @(posedge clk);
    clr_req <= 1'b0;
  endtask

  task automatic send(input int i, input word_t w);
    @(posedge clk);
    rx_word[i] <= w;
    rx_valid[i] <= 1'b1;
    @(posedge clk);
    rx_valid[i] <= 1'b0;
  endtask

  task automatic wait_up(input int n);
    int k;
    k = 0;
    while (up_q.size() < n && k < 300)
    begin
      @(posedge clk);
      k++;
    end
    chk(up_q.size() == n, "word count");
  endtask

  task automatic t_simul();
    clr();
    send(1, 32'h1234_5699);
    send(0, 32'h1234_5622);
    repeat (20) @(posedge clk);
    chk(up_q.size() == 0, "foreign label taken");
    @(posedge clk);
    rx_word <= {32'h3000_0033, 32'h2000_0022, 32'h1000_0011};
    rx_valid <= 3'b111;
    @(posedge clk);
    rx_valid <= 3'b000;
    wait_up(3);
    up_q.sort();
    chk(up_q[0] === 32'h1000_0011, "word 0");
    chk(up_q[1] === 32'h2000_0022, "word 1");
    chk(up_q[2] === 32'h3000_0033, "word 2");
    $display("simultaneous test done");
  endtask

  task automatic t_rate();
    clr();
    repeat (20) @(posedge clk);
    send(0, 32'h0000_0111);
    repeat (4) @(posedge clk);
    chk(fast_seen === 3'b000, "lone word flagged");
    send(0, 32'h0000_0211);
    wait_up(2);
    chk(fast_seen === 3'b001 && up_q[1] === 32'h0000_0211, "close pair");
    clr();
    repeat (20) @(posedge clk);
    send(0, 32'h0000_0311);
    wait_up(1);
    chk(fast_seen === 3'b000, "spaced word flagged");
    $display("rate test done");
  endtask

  task automatic t_stall();
    int j;
    clr();
    @(posedge clk);
    stall <= 1'b1;
    for (j = 0; j < 4; j++)
    begin
      send(0, {16'h00c0, 8'(j), 8'h11});
      repeat (20) @(posedge clk);
    end
    send(1, 32'h00c1_0022);
    send(2, 32'h00c2_0033);
    repeat (20) @(posedge clk);
    send(2, 32'h00c2_ff33);
    repeat (4) @(posedge clk);
    chk(drop_seen === 3'b100 && up_q.size() == 0, "full slot");
    stall <= 1'b0;
    wait_up(6);
    for (j = 0; j < 4; j++)
      chk(up_q[j] === {16'h00c0, 8'(j), 8'h11}, "queue order");
    chk(up_q[4] === 32'h00c2_0033 || up_q[5] === 32'h00c2_0033, "older kept");
    chk(up_count === 16'h000c, "uplink count");
    $display("stall test done");
  endtask

  task automatic t_route();
    sa_t sa[4] = '{5'h01, 5'h02, 5'h00, 5'h03};
    word_t w;
    int n;
    foreach (sa[j])
    begin
      clr();
      @(posedge clk);
      echo <= 1'b1;
      route_sa <= sa[j];
      w = {8'h5a, 3'h0, sa[j], 16'h0011};
      send(0, w);
      n = 0;
      while (tx_valid === 2'b00 && rej_seen !== 1'b1 && n < 100)
      begin
        @(posedge clk);
        n++;
      end
      repeat (3) @(posedge clk);
      if (j < 2)
      begin
        chk(tx_valid === 2'(1 << j) && tx_word[j] === w, "routed word");
        tx_ready[j] <= 1'b1;
        @(posedge clk);
        tx_ready[j] <= 1'b0;
        repeat (2) @(posedge clk);
      end
      else
        chk(rej_seen === 1'b1 && tx_valid === 2'b00, "bad subaddress");
    end
    chk(dn_count === 16'h0002 && tx_valid === 2'b00, "handed count");
    $display("route test done");
  endtask

  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(r_ready === 1'b1 && t_valid === 1'b0, "reset state");
    t_simul();
    t_rate();
    t_stall();
    t_route();
    tally_and_finish();
  end

  initial
  begin
    repeat (4000) @(posedge clk);
    $display("wrong value at %0t: timeout", $time);
    fails++;
    tally_and_finish();
  end
endmodule // test_exchange_buffer_unit
